// ### verilog/ebps_defines.vh
// constants for the expansion bus phase sequencer
`ifndef EBPS_DEFINES_VH
`define EBPS_DEFINES_VH
`define EBPS_OFF_TIMING0    6'h00
`define EBPS_OFF_TIMING7    6'h1C
`define EBPS_OFF_ACC_ADDR   6'h20
`define EBPS_OFF_ACC_WDATA  6'h24
`define EBPS_OFF_ACC_CTRL   6'h28
`define EBPS_OFF_STATUS     6'h2C
`define EBPS_F_CS_EN        31
`define EBPS_F_T1_HI        29
`define EBPS_F_T1_LO        28
`define EBPS_F_T2_HI        27
`define EBPS_F_T2_LO        26
`define EBPS_F_T3_HI        25
`define EBPS_F_T3_LO        22
`define EBPS_F_T4_HI        21
`define EBPS_F_T4_LO        20
`define EBPS_F_T5_HI        19
`define EBPS_F_T5_LO        16
`define EBPS_F_KIND_HI      15
`define EBPS_F_KIND_LO      14
`define EBPS_F_RDY_POL      5
`define EBPS_F_MUX_EN       4
`define EBPS_F_WR_EN        1
`define EBPS_KIND_STROBE_A  2'h0
`define EBPS_KIND_STROBE_B  2'h1
`define EBPS_KIND_HOST_PORT 2'h2
`define EBPS_RST_TIMING0    32'hBFFF3C40
`define EBPS_RST_TIMINGN    32'h00000000
`define EBPS_RESP_OKAY      2'h0
`define EBPS_RESP_SLVERR    2'h2
`endif

// ### verilog/ebps_sequencer.v
// expansion bus phase sequencer with axi4-lite register access
// Contract
// [R1] access runs address, setup, strobe, hold, recovery
// [R2] address phase 1 clock, 2 multiplexed
// [R3] address extension adds clocks, strobe drops early
// [R4] multiplexed: low address on data bus
// [R5] second address clock: write data or release
// [R6] software sets address extension two for host
// [R7] chip select through setup, strobe, hold
// [R8] setup extension adds one to three clocks
// [R9] software sets setup extension two for host
// [R10] strobe phase asserts read or write strobe
// [R11] strobe extension adds one to fifteen clocks
// [R12] software sets strobe extension one for host
// [R13] hold extension adds one to three clocks
// [R14] recovery extension adds one to fifteen clocks
// [R15] read wait stretches strobe, release enters hold
// [R16] wait ignored outside read strobe phase
// [R17] chip selects four-seven use own ready
// [R18] host mode drives half, register, chip select
// [R19] byte half low first, high second
// [R20] host mode ignores bits thirteen to ten
// [R21] register select encodes dsp port target
// [R22] dsp port auto-increments its address register
// [R23] cycle kind selects strobe style or host
// [R24] mode bit four selects multiplexed access
// [R25] ready polarity bit: clear low, set high
// [R26] zero extension adds nothing, n adds n
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "ebps_defines.vh"

module ebps_sequencer
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [5:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [5:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // expansion bus pins
  output reg  [23:0] expansion_address,
  output reg  [15:0] data_out,
  output reg         data_oe,
  input  wire [15:0] data_in,
  output reg         address_latch_strobe,
  output reg  [7:0]  chip_select_n,
  output reg         read_strobe_n,
  output reg         write_strobe_n,
  output reg         data_strobe_n,
  output reg         read_not_write,
  input  wire        slow_device_wait_n,
  input  wire [3:0]  host_port_ready
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_ADDR  = 3'd1;
  localparam [2:0] ST_SETUP = 3'd2;
  localparam [2:0] ST_STRB  = 3'd3;
  localparam [2:0] ST_HOLD  = 3'd4;
  localparam [2:0] ST_RECOV = 3'd5;

  reg  [31:0] timing_q [0:7];
  reg  [26:0] acc_addr_q;
  reg  [15:0] acc_wdata_q;
  reg  [15:0] rdata_q;
  reg         busy_q;
  reg         err_q;
  reg         wr_q;
  reg  [2:0]  cs_q;
  reg  [2:0]  st_q;
  reg  [3:0]  cnt_q;
  reg         half_q;
  reg         waited_q;
  reg  [2:0]  cap_q;
  reg         cap_half_q;
  reg  [15:0] din_s1_q;
  reg  [15:0] din_s2_q;
  reg  [4:0]  in_s1_q;
  reg  [4:0]  in_s2_q;
  reg         aw_held_q;
  reg         w_held_q;
  reg  [5:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  // decode of the active chip select's timing word
  wire [31:0] tim      = timing_q[cs_q];
  wire [1:0]  ext_t1   = tim[`EBPS_F_T1_HI:`EBPS_F_T1_LO];
  wire [1:0]  ext_t2   = tim[`EBPS_F_T2_HI:`EBPS_F_T2_LO];
  wire [3:0]  ext_t3   = tim[`EBPS_F_T3_HI:`EBPS_F_T3_LO];
  wire [1:0]  ext_t4   = tim[`EBPS_F_T4_HI:`EBPS_F_T4_LO];
  wire [3:0]  ext_t5   = tim[`EBPS_F_T5_HI:`EBPS_F_T5_LO];
  wire [1:0]  kind     = tim[`EBPS_F_KIND_HI:`EBPS_F_KIND_LO];
  wire        mux      = tim[`EBPS_F_MUX_EN];                   // [R24]
  wire        host     = (kind == `EBPS_KIND_HOST_PORT);        // [R23]
  // bits 13:10 are never read, so host mode disregards them too [R20]
  wire        wait_act = ~in_s2_q[4];
  wire        rdy_raw  = in_s2_q[cs_q[1:0]];                    // [R17]
  wire        rdy_ok   = tim[`EBPS_F_RDY_POL] ? rdy_raw : ~rdy_raw; // [R25]
  wire        last     = (cnt_q == 4'h0);
  // a read sample still in flight counts as busy, so status never shows stale data
  wire        busy_any = busy_q | (|cap_q);

  // validity of a new request against the target's timing word
  wire [31:0] ntim     = timing_q[acc_addr_q[26:24]];
  wire [1:0]  nkind    = ntim[`EBPS_F_KIND_HI:`EBPS_F_KIND_LO];
  wire        nbad     = ~ntim[`EBPS_F_CS_EN] | (nkind == 2'h3) |
                         ((nkind == `EBPS_KIND_HOST_PORT) & ~acc_addr_q[26]); // [R23]

  // axi write path
  wire        wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire        wr_timing = (awaddr_q[5] == 1'b0);
  wire [2:0]  widx     = awaddr_q[4:2];
  wire        ctrl_hit = (awaddr_q == `EBPS_OFF_ACC_CTRL);
  wire        wr_known = wr_timing | (awaddr_q == `EBPS_OFF_ACC_ADDR) |
                         (awaddr_q == `EBPS_OFF_ACC_WDATA) | ctrl_hit |
                         (awaddr_q == `EBPS_OFF_STATUS);
  wire        start    = wr_fire & ctrl_hit & wstrb_q[0] & wdata_q[0] & ~busy_any;
  wire        req_wr   = wdata_q[1];
  wire        prot     = req_wr & ~ntim[`EBPS_F_WR_EN];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 6'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EBPS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `EBPS_RESP_OKAY : `EBPS_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // timing words and access registers
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_timing
      always @(posedge aclk)
      begin
        if (!aresetn)
          timing_q[g] <= (g == 0) ? `EBPS_RST_TIMING0 : `EBPS_RST_TIMINGN;
        else if (wr_fire & wr_timing & (widx == g))
          timing_q[g] <= merge(timing_q[g], wdata_q, wstrb_q);
      end
    end
  endgenerate

  wire [31:0] acc_addr_m  = merge({5'h00, acc_addr_q}, wdata_q, wstrb_q);
  wire [31:0] acc_wdata_m = merge({16'h0000, acc_wdata_q}, wdata_q, wstrb_q);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_addr_q  <= 27'h0000000;
      acc_wdata_q <= 16'h0000;
    end
    else if (wr_fire & ~busy_q)
    begin
      if (awaddr_q == `EBPS_OFF_ACC_ADDR)
        acc_addr_q <= acc_addr_m[26:0];
      if (awaddr_q == `EBPS_OFF_ACC_WDATA)
        acc_wdata_q <= acc_wdata_m[15:0];
    end
  end

  // axi read path
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_ok  = 1'b1;
    if (s_axi_araddr[5] == 1'b0)
      rd_mux = timing_q[s_axi_araddr[4:2]];
    else if (s_axi_araddr == `EBPS_OFF_ACC_ADDR)
      rd_mux = {5'h00, acc_addr_q};
    else if (s_axi_araddr == `EBPS_OFF_ACC_WDATA)
      rd_mux = {16'h0000, acc_wdata_q};
    else if (s_axi_araddr == `EBPS_OFF_ACC_CTRL)
      rd_mux = {29'h00000000, wr_q, 2'h0};
    else if (s_axi_araddr == `EBPS_OFF_STATUS)
      rd_mux = {rdata_q, 13'h0000, st_q == ST_IDLE ? 1'b0 : 1'b1, err_q, busy_any};
    else
      rd_ok = 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EBPS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `EBPS_RESP_OKAY : `EBPS_RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_s1_q  <= 5'h1F;
      in_s2_q  <= 5'h1F;
      din_s1_q <= 16'h0000;
      din_s2_q <= 16'h0000;
    end
    else
    begin
      in_s1_q  <= {slow_device_wait_n, host_port_ready};
      in_s2_q  <= in_s1_q;
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // phase sequencer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q     <= ST_IDLE;
      cnt_q    <= 4'h0;
      busy_q   <= 1'b0;
      err_q    <= 1'b0;
      wr_q     <= 1'b0;
      cs_q     <= 3'h0;
      half_q   <= 1'b0;
      waited_q <= 1'b0;
      cap_q    <= 3'h0;
      cap_half_q <= 1'b0;
      rdata_q  <= 16'h0000;
    end
    else
    begin
      cap_q <= {cap_q[1:0], 1'b0};
      // pins lag state by one, so the last strobe pin clock is one after the
      // last strobe state clock; the sample lands two flops after that
      if (cap_q[2] & ~wr_q)
      begin
        if (host & cap_half_q)
          rdata_q[15:8] <= din_s2_q[7:0];
        else if (host)
          rdata_q[7:0] <= din_s2_q[7:0];
        else
          rdata_q <= din_s2_q;
      end
      case (st_q)
        ST_IDLE:
        begin
          if (start)
          begin
            err_q <= nbad | prot;
            if (!(nbad | prot))
            begin
              busy_q <= 1'b1;
              wr_q   <= req_wr;
              cs_q   <= acc_addr_q[26:24];
              half_q <= 1'b0;
              st_q   <= ST_ADDR;                                // [R1]
              cnt_q  <= {2'h0, ntim[`EBPS_F_T1_HI:`EBPS_F_T1_LO]} +
                        {3'h0, ntim[`EBPS_F_MUX_EN]};          // [R2] [R3] [R26]
            end
          end
        end
        ST_ADDR:
          if (last)
          begin
            st_q  <= ST_SETUP;
            cnt_q <= {2'h0, ext_t2};                            // [R8] [R26]
          end
          else
            cnt_q <= cnt_q - 4'h1;
        ST_SETUP:
          if (last)
          begin
            st_q     <= ST_STRB;
            cnt_q    <= ext_t3;                                 // [R11] [R26]
            waited_q <= 1'b0;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        ST_STRB:
        begin
          if (!last)
            cnt_q <= cnt_q - 4'h1;
          if (!wr_q & !host & wait_act)                         // [R16]
            waited_q <= 1'b1;
          // wait release ends strobe at once, whatever is left [R15]
          if ((!wr_q & !host & waited_q & !wait_act) ||
              (last & !(!wr_q & !host & wait_act) & (!host | rdy_ok)))
          begin
            st_q  <= ST_HOLD;
            cnt_q <= {2'h0, ext_t4};                            // [R13] [R26]
            cap_q <= {cap_q[1:0], 1'b1};
            cap_half_q <= half_q;
          end
        end
        ST_HOLD:
          if (last)
          begin
            st_q  <= ST_RECOV;
            cnt_q <= ext_t5;                                    // [R14] [R26]
          end
          else
            cnt_q <= cnt_q - 4'h1;
        ST_RECOV:
          if (!last)
            cnt_q <= cnt_q - 4'h1;
          else if (host & !half_q)
          begin
            half_q <= 1'b1;                                     // [R19]
            st_q   <= ST_ADDR;
            cnt_q  <= {2'h0, ext_t1} + {3'h0, mux};
          end
          else
          begin
            st_q   <= ST_IDLE;
            busy_q <= 1'b0;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // pin drive, one clock behind the phase state
  wire        first_addr = (st_q == ST_ADDR) &
                           (cnt_q == ({2'h0, ext_t1} + {3'h0, mux}));
  wire        in_cycle   = (st_q != ST_IDLE) & (st_q != ST_RECOV);
  wire        strb_on    = (st_q == ST_STRB);
  wire [23:0] addr_pins  = host ? {acc_addr_q[23:22], acc_addr_q[21:3],
                                   acc_addr_q[2:1], half_q}     // [R18] [R21]
                                : acc_addr_q[23:0];
  wire [15:0] wbyte      = host ? {8'h00, half_q ? acc_wdata_q[15:8] : acc_wdata_q[7:0]}
                                : acc_wdata_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      expansion_address    <= 24'h000000;
      data_out             <= 16'h0000;
      data_oe              <= 1'b0;
      address_latch_strobe <= 1'b0;
      chip_select_n        <= 8'hFF;
      read_strobe_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      data_strobe_n        <= 1'b1;
      read_not_write       <= 1'b1;
    end
    else
    begin
      expansion_address <= in_cycle ? addr_pins : 24'h000000;   // [R10]
      // strobe held high all but the final address clock, never zero long
      address_latch_strobe <= (st_q == ST_ADDR) & (!last | first_addr); // [R3] [R4]
      if (st_q == ST_ADDR && mux && first_addr)
      begin
        data_out <= addr_pins[15:0];                            // [R4]
        data_oe  <= 1'b1;
      end
      else if (in_cycle & wr_q)
      begin
        data_out <= wbyte;                                      // [R5] [R10]
        data_oe  <= 1'b1;
      end
      else
      begin
        data_out <= 16'h0000;
        data_oe  <= 1'b0;                                       // [R5]
      end
      chip_select_n <= 8'hFF;
      if ((st_q == ST_SETUP) | strb_on | (st_q == ST_HOLD))
        chip_select_n[cs_q] <= 1'b0;                            // [R7]
      read_strobe_n  <= ~(strb_on & !wr_q & (kind != `EBPS_KIND_STROBE_B)); // [R10] [R23]
      write_strobe_n <= ~(strb_on & wr_q & (kind != `EBPS_KIND_STROBE_B));
      data_strobe_n  <= ~(strb_on & (kind == `EBPS_KIND_STROBE_B));
      read_not_write <= ~(in_cycle & wr_q);
    end
  end

endmodule // ebps_sequencer

// ### verification/ebps_sequencer_asserts.sv
// concurrent checks on the expansion bus pins of the phase sequencer
`timescale 1ns/1ps
module ebps_seq_asserts
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // expansion bus pins
  input wire [23:0] expansion_address,
  input wire        data_oe,
  input wire        address_latch_strobe,
  input wire [7:0]  chip_select_n,
  input wire        read_strobe_n,
  input wire        write_strobe_n,
  input wire        data_strobe_n,
  input wire        read_not_write
);
  wire any_st = ~(read_strobe_n & write_strobe_n & data_strobe_n);
  wire cs_on  = chip_select_n != 8'hFF;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_strobe_end;
    $rose(read_strobe_n) || $rose(write_strobe_n) || $rose(data_strobe_n);
  endsequence
  sequence s_cs_release;
    $rose(&chip_select_n);
  endsequence
  a_strobe_in_cs: assert property (any_st |-> cs_on)
    else $error("strobe outside chip select");
  a_cs_ahead: assert property ($rose(any_st) |-> $past(cs_on))
    else $error("chip select not ahead of strobe");
  a_hold_after: assert property (s_strobe_end |-> cs_on)
    else $error("no hold clock after strobe");
  a_recovery_gap: assert property (s_cs_release |-> !cs_on [*3])
    else $error("chip select back too soon");
  a_ale_before_cs: assert property (address_latch_strobe |-> !cs_on)
    else $error("latch strobe with chip select");
  a_one_select: assert property ($onehot0(~chip_select_n))
    else $error("several chip selects low");
  a_read_released: assert property (!read_strobe_n |-> !data_oe && read_not_write)
    else $error("data bus driven on read");
  a_write_drives: assert property (!write_strobe_n |-> data_oe && !read_not_write)
    else $error("data bus idle on write");
  a_addr_steady: assert property (any_st && $past(any_st) |-> $stable(expansion_address))
    else $error("address moved in strobe");
endmodule // ebps_seq_asserts
bind ebps_sequencer ebps_seq_asserts i_chk (.*);

// ### verification/ebps_periph_model.sv
// slow peripheral and dsp port model on the far side of the expansion bus
`timescale 1ns/1ps
module ebps_periph_model
(
  // clock
  input  wire        aclk,
  // bench control
  input  wire [4:0]  wait_len,
  input  wire        rdy_pol,
  // expansion bus pins
  input  wire [23:0] expansion_address,
  input  wire [7:0]  chip_select_n,
  input  wire        read_strobe_n,
  input  wire        write_strobe_n,
  input  wire        data_strobe_n,
  input  wire        read_not_write,
  output wire [15:0] data_in,
  output reg         slow_device_wait_n = 1'b1,
  output reg  [3:0]  host_port_ready = 4'h0
);
  reg  [4:0] st_age = 5'h00;
  reg  [2:0] cs_age = 3'h0;
  reg [15:0] idle_q = 16'h0000;
  reg        st_was = 1'b0;
  reg  [7:0] port_addr_q = 8'h00;
  wire       st_on  = chip_select_n != 8'hFF && !(read_strobe_n & write_strobe_n & data_strobe_n);
  wire [3:0] act    = ~chip_select_n[7:4] & {4{cs_age > 3'h1}};
  // data answers while the strobe is low; released bus flips every clock so a stale sample cannot pass
  assign data_in = st_on && read_not_write ? {~expansion_address[7:0], expansion_address[7:0]} : idle_q;
  always @(posedge aclk)
  begin
    idle_q <= ~idle_q;
    st_was <= st_on;
    // dsp steps its address register after the second byte of a data access
    if (st_was && !st_on && chip_select_n[7:4] != 4'hF && expansion_address[2:0] == 3'h3)
      port_addr_q <= port_addr_q + 8'h01;
    st_age <= st_on ? st_age + 5'h01 : 5'h00;
    slow_device_wait_n <= !(st_on && st_age < wait_len);
    cs_age <= chip_select_n == 8'hFF ? 3'h0 : (cs_age == 3'h7 ? cs_age : cs_age + 3'h1);
    // dsp reports not ready for the first clocks of each select
    host_port_ready <= rdy_pol ? act : ~act;
  end
endmodule // ebps_periph_model

// ### verification/expansion_bus_phase_sequencer_test.sv
// self-checking bench for the expansion bus phase sequencer
`timescale 1ns/1ps
`include "ebps_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module expansion_bus_phase_sequencer_test;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hF;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] expansion_address;
  wire [15:0] data_out, data_in;
  wire [7:0]  chip_select_n;
  wire        data_oe, address_latch_strobe, read_strobe_n, write_strobe_n, data_strobe_n;
  wire        read_not_write, slow_device_wait_n;
  wire [3:0]  host_port_ready;
  reg  [4:0]  wait_len = 5'h00;
  reg         rdy_pol = 1'b0, st_q = 1'b0, ale_q = 1'b0;
  reg  [31:0] rdv;
  reg  [1:0]  resp, t1, t2, t4;
  reg  [3:0]  t3;
  reg         mux, w;
  reg  [15:0] wd, mux_a;
  reg  [23:0] cap [0:1];
  integer     n_ale, n_su, n_st, n_ho, n_pass, i, miscompares = 0, cmp_count = 0;
  wire        any_st = ~(read_strobe_n & write_strobe_n & data_strobe_n);

  ebps_sequencer i_dut (.*);
  ebps_periph_model i_dev (.*);

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  // pin monitor: phase lengths, captured address and data
  always @(posedge aclk)
  begin
    st_q <= any_st;
    ale_q <= address_latch_strobe;
    if (address_latch_strobe) n_ale <= n_ale + 1;
    if (address_latch_strobe && !ale_q) mux_a <= data_out;
    if (any_st && !st_q)
    begin
      n_pass <= n_pass + 1;
      cap[n_pass % 2] <= expansion_address;
    end
    if (!write_strobe_n) wd <= data_out;
    if (chip_select_n != 8'hFF)
    begin
      if (any_st) n_st <= n_st + 1;
      else if (n_st == 0) n_su <= n_su + 1;
      else n_ho <= n_ho + 1;
    end
  end

  task automatic wr(input [5:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        n++;
      end while (s_axi_bvalid !== 1'b1 && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic rd(input [5:0] a);
    integer n;
    begin
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        n++;
      end while (s_axi_rvalid !== 1'b1 && n < 200);
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask

  // one expansion access, polled until the sequencer is idle again
  task automatic acc(input [2:0] cs, input [23:0] a, input wb, input [15:0] d);
    integer n;
    begin
      n_ale = 0;
      n_su = 0;
      n_st = 0;
      n_ho = 0;
      n_pass = 0;
      n = 0;
      wr(`EBPS_OFF_ACC_ADDR, {5'h00, cs, a});
      wr(`EBPS_OFF_ACC_WDATA, {16'h0000, d});
      wr(`EBPS_OFF_ACC_CTRL, {30'h0, wb, 1'b1});
      do
      begin
        rd(`EBPS_OFF_STATUS);
        n++;
      end while (rdv[0] !== 1'b0 && n < 100);
      `CHK(rdv[0], 1'b0)
    end
  endtask

  // timing word; bits 13:10 set to show they are ignored in host mode
  function [31:0] tw(input [1:0] a1, a2, input [3:0] a3, input [1:0] a4, k, input p, m);
    tw = {2'h2, a1, a2, a3, a4, 4'h3, k, 4'hF, 4'h0, p, m, 4'h2};
  endfunction

  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  initial
  begin
    #(8 * 60000);
    miscompares++;
    tally_and_finish;
  end

  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EBPS_OFF_TIMING0);
    `CHK(rdv, `EBPS_RST_TIMING0)
    rd(6'h04);
    `CHK(rdv, `EBPS_RST_TIMINGN)
    rd(6'h30);
    `CHK(resp, `EBPS_RESP_SLVERR)
    wr(6'h3C, 32'h1);
    `CHK(resp, `EBPS_RESP_SLVERR)
    wr(6'h04, 32'h12345678);
    rd(6'h04);
    `CHK(rdv, 32'h12345678)
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      case (i)
        0: {t1, t2, t3, t4, mux, w} = {2'h0, 2'h0, 4'h0, 2'h0, 1'b0, 1'b1};
        1: {t1, t2, t3, t4, mux, w} = {2'h3, 2'h3, 4'hF, 2'h3, 1'b1, 1'b0};
        2: {t1, t2, t3, t4, mux, w} = {2'h1, 2'h2, 4'h5, 2'h1, 1'b1, 1'b1};
        default: {t1, t2, t3, t4, mux, w} = {2'h2, 2'h1, 4'h3, 2'h2, 1'b0, 1'b0};
      endcase
      wr(6'h04, tw(t1, t2, t3, t4, {1'b0, i[0]}, 1'b0, mux));
      acc(3'h1, 24'h3C5A10 + i, w, 16'hC3A5 ^ i);
      `CHK(n_ale, (t1 + mux > 0) ? t1 + mux : 1)
      `CHK(n_su, 1 + t2)
      `CHK(n_st, 1 + t3)
      `CHK(n_ho, 1 + t4)
      if (mux) `CHK(mux_a, 16'h5A10 + i)
      if (w) `CHK(wd, 16'hC3A5 ^ i)
      else `CHK(rdv[31:16], {8'hEF - i[7:0], 8'h10 + i[7:0]})
    end
    $display("test phases done");
    wait_len <= 5'h0A;
    wr(6'h04, tw(2'h0, 2'h0, 4'h8, 2'h0, 2'h0, 1'b0, 1'b0));
    acc(3'h1, 24'h000040, 1'b0, 16'h0);
    `CHK(n_st > 9 && n_st < 17, 1'b1)
    acc(3'h1, 24'h000040, 1'b1, 16'h0);
    `CHK(n_st, 9)
    wait_len <= 5'h00;
    $display("test wait done");
    for (i = 0; i < 4; i++)
    begin
      rdy_pol <= i[0];
      wr(6'h14, tw(2'h2, 2'h2, 4'h1, 2'h0, 2'h2, i[0], 1'b0));
      acc(3'h5, {2'h2, 19'h0, i[1:0], 1'b0}, 1'b0, 16'h0);
      `CHK(n_pass, 2)
      `CHK({cap[1][0], cap[0][0]}, 2'h2)
      `CHK(cap[0][2:1], i[1:0])
      `CHK(cap[1][23:22], 2'h2)
      `CHK(rdv[31:16], 16'h0100 | {2{5'h00, i[1:0], 1'b0}})
    end
    `CHK(i_dev.port_addr_q, 8'h01)
    $display("test host port done");
    for (i = 0; i < 3; i++)
    begin
      wr(6'h08, tw(2'h0, 2'h0, 4'h0, 2'h0, 2'h3, 1'b0, 1'b0));
      wr(6'h0C, tw(2'h0, 2'h0, 4'h0, 2'h0, 2'h2, 1'b0, 1'b0));
      wr(6'h04, tw(2'h0, 2'h0, 4'h0, 2'h0, 2'h0, 1'b0, 1'b0) & 32'hFFFFFFFD);
      acc(3'h2 + (i == 1) - 2 * (i == 2), 24'h0, i == 2, 16'h0);
      `CHK(rdv[1], 1'b1)
      `CHK(n_su, 0)
    end
    $display("test errors done");
    tally_and_finish;
  end
endmodule // expansion_bus_phase_sequencer_test
